/* verilog/fsp_defs.vh */
// Constants shared by the flash status and protection block.
// Assumes it is included by its bare name, once per design file.
`ifndef FSP_DEFS_VH
`define FSP_DEFS_VH

// Status word bit positions
`define FSP_BIT_BUSY   0
`define FSP_BIT_WEL    1
`define FSP_BP_LSB     2
`define FSP_BP_MSB     6
`define FSP_SRP_LSB    7
`define FSP_SRP_MSB    8
`define FSP_BIT_QE     9
`define FSP_BIT_HPF    10
`define FSP_LB_LSB     11
`define FSP_LB_MSB     13
`define FSP_BIT_CMP    14
`define FSP_BIT_SUS    15

// Non-volatile contents held in storage after a power cycle
`define FSP_NV_DEFAULT 16'h0000

// Lock-select encodings
`define FSP_LOCK_SW    2'h0
`define FSP_LOCK_HW    2'h1
`define FSP_LOCK_PWR   2'h2
`define FSP_LOCK_OTP   2'h3

// Command codes
`define FSP_OP_WRITE_ENABLE_CMD    8'h06
`define FSP_OP_WRITE_DISABLE_CMD    8'h04
`define FSP_OP_RDSR0   8'h05
`define FSP_OP_RDSR1   8'h35
`define FSP_OP_STATUS_WRITE_CMD    8'h01
`define FSP_OP_WRSR1   8'h31
`define FSP_OP_PP      8'h02
`define FSP_OP_SE      8'h20
`define FSP_OP_BE32    8'h52
`define FSP_OP_BE64    8'hD8
`define FSP_OP_CE0     8'h60
`define FSP_OP_CE1     8'hC7
`define FSP_OP_SUSP    8'h75
`define FSP_OP_RESUME  8'h7A

// Array operation kinds
`define FSP_KIND_PP    2'h0
`define FSP_KIND_SE    2'h1
`define FSP_KIND_BE    2'h2
`define FSP_KIND_CE    2'h3

// Array geometry in bytes
`define FSP_ARRAY_SZ   20'h80000
`define FSP_BLOCK_SZ   20'h10000
`define FSP_SECT_SZ    20'h01000

// Busy durations in SYS_CLK cycles
`define FSP_SR_CYC     16'h0020
`define FSP_PP_CYC     16'h0040
`define FSP_ER_CYC     16'h0100
`define FSP_CE_CYC     16'h0400

`endif

/* verilog/fsp_sync.v */
// Two-flop synchroniser for a group of pin levels.
// Assumes each bit is an independent level from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none

module fsp_sync #(
  parameter         W    = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  // Clock and reset
  input  wire         clk,
  input  wire         rst_n,
  // Pin levels in and synchronised levels out
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);

  reg [W-1:0] meta_reg;

  // First stage feeds only the second stage
  always @(posedge clk) begin
    if (!rst_n) begin
      meta_reg <= INIT;
      q        <= INIT;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule

`default_nettype wire

/* verilog/fsp_prot_decode.v */
// Decoder from block-protect field and complement bit to a protected range.
// Assumes a 19-bit byte address into the array; purely combinational.
`timescale 1ns/1ps
`default_nettype none
`include "fsp_defs.vh"

module fsp_prot_decode (
  // Protection setting
  input  wire [4:0]  bp,
  input  wire        cmp,
  // Address under test and results
  input  wire [18:0] addr,
  output reg         hit,
  output reg         none
);

  reg [19:0] sz;
  reg        top;
  reg [19:0] psz;
  reg        ptop;

  // Normal region as size plus anchor, then optional complement
  always @* begin
    sz   = 20'h00000;
    top  = ~bp[3];
    psz  = 20'h00000;
    ptop = 1'b0;
    // (R4) normal decode
    if (bp[2:0] == 3'h0) begin
      sz = 20'h00000;
    end else if (!bp[4]) begin
      if (bp[2]) begin
        sz = `FSP_ARRAY_SZ;
      end else begin
        case (bp[1:0])
          2'h1:    sz = `FSP_BLOCK_SZ;
          2'h2:    sz = `FSP_BLOCK_SZ << 1;
          default: sz = `FSP_BLOCK_SZ << 2;
        endcase
      end
    end else if (bp[2:0] == 3'h7) begin
      sz = `FSP_ARRAY_SZ;
    end else begin
      case (bp[2:0])
        3'h1:    sz = `FSP_SECT_SZ;
        3'h2:    sz = `FSP_SECT_SZ << 1;
        3'h3:    sz = `FSP_SECT_SZ << 2;
        default: sz = `FSP_SECT_SZ << 3;
      endcase
    end
    // (R1) (R2) (R3) complement flips size and anchor
    if (cmp) begin
      psz  = `FSP_ARRAY_SZ - sz;
      ptop = ~top;
    end else begin
      psz  = sz;
      ptop = top;
    end
    none = (psz == 20'h00000);
    if (ptop) begin
      hit = ({1'b0, addr} >= (`FSP_ARRAY_SZ - psz));
    end else begin
      hit = ({1'b0, addr} < psz);
    end
  end

endmodule

`default_nettype wire

/* verilog/fsp_status_protect.v */
// Status word and array write protection of a 512KB serial flash.
// Assumes SCLK, CS_N, SI, WP_N and HIGH_PERF are asynchronous pins that
// SYS_CLK oversamples; SCLK must be well below a quarter of SYS_CLK.
//
// Functional notes
// (R1) Complement with low field bits zero protects all; ten codes protect none.
// (R2) Complement, field bit four clear: bit three picks region, 7/8, 3/4, 1/2.
// (R3) Complement, field bit four set: all except 4K to 32K top or bottom.
// (R4) Without complement: none, 64KB fractions, 4K-32K areas, or all.
// (R5) Status word is 16 bits laid out from suspended flag down to busy.
// (R6) Busy reads 1 during program, erase or status write, else 0.
// (R7) Write latch clear refuses status write, program and erase.
// (R8) Write enable sets latch; disable, power-up and completions clear it.
// (R9) Block-protect bits are non-volatile, default 0, changed by status write.
// (R10) Program and erase into the protected region are rejected.
// (R11) Hardware-protected mode refuses block-protect writes.
// (R12) Chip erase runs only when nothing is protected.
// (R13) Lock-select 00: pin ignored, status writable with latch set.
// (R14) Lock-select 01: low pin locks status word, high pin allows writes.
// (R15) Lock-select 10 locks until power cycle, which restores 00.
// (R16) Lock-select 11 locks the status word permanently.
// (R17) Quad enable default 0; when 1, protect and hold pins become data.
// (R18) Host should not set quad enable with those pins tied to rails.
// (R19) High-performance flag reads 1 while that mode is active.
// (R20) Security lock bits are one-time settable, each alone, never cleared.
// (R21) Complement bit is non-volatile, default 0, selects decode.
// (R22) Suspended flag set by suspend, cleared by resume or power cycle.
// (R23) Power-up reloads stored bits and clears busy, latch and suspended.
`timescale 1ns/1ps
`default_nettype none
`include "fsp_defs.vh"

module fsp_status_protect #(
  parameter [15:0] NV_INIT = `FSP_NV_DEFAULT,
  parameter [15:0] SR_CYC  = `FSP_SR_CYC,
  parameter [15:0] PP_CYC  = `FSP_PP_CYC,
  parameter [15:0] ER_CYC  = `FSP_ER_CYC,
  parameter [15:0] CE_CYC  = `FSP_CE_CYC
) (
  // System
  input  wire        SYS_CLK,
  input  wire        RST_N,
  // Serial link pins
  input  wire        CS_N,
  input  wire        SCLK,
  input  wire        SI,
  output reg         SO,
  output reg         SO_OE_N,
  // Protection and mode pins
  input  wire        WP_N,
  input  wire        HIGH_PERF,
  // Array operation request
  output reg         OP_START,
  output reg  [1:0]  OP_KIND,
  output reg  [18:0] OP_ADDR,
  output reg         BUSY,
  // Mode outputs
  output reg         QUAD_EN,
  output reg  [2:0]  SEC_LOCK
);

  ////////////////////////////////////////////////////////////////////////
  // Functions

  // Status word lock from lock-select bits and effective pin level
  function sr_locked;
    input [1:0] sel;
    input       wp;
    begin
      case (sel)
        `FSP_LOCK_SW:  sr_locked = 1'b0;
        `FSP_LOCK_HW:  sr_locked = ~wp;
        `FSP_LOCK_PWR: sr_locked = 1'b1;
        default:       sr_locked = 1'b1;
      endcase
    end
  endfunction

  // Busy duration for an array operation kind
  function [15:0] op_cycles;
    input [1:0] kind;
    begin
      case (kind)
        `FSP_KIND_PP: op_cycles = PP_CYC;
        `FSP_KIND_CE: op_cycles = CE_CYC;
        default:      op_cycles = ER_CYC;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and edge detection

  wire [4:0] pins_s;

  fsp_sync #(
    .W    (5),
    .INIT (5'h12)
  ) u_sync (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .d     ({CS_N, SCLK, SI, WP_N, HIGH_PERF}),
    .q     (pins_s)
  );

  wire cs_n_s = pins_s[4];
  wire sclk_s = pins_s[3];
  wire si_s   = pins_s[2];
  wire wp_s   = pins_s[1];
  wire hpm_s  = pins_s[0];

  reg sclk_d_reg;
  reg cs_d_reg;

  // Previous synchronised levels for edge finding
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      sclk_d_reg <= 1'b0;
      cs_d_reg   <= 1'b1;
    end else begin
      sclk_d_reg <= sclk_s;
      cs_d_reg   <= cs_n_s;
    end
  end

  wire sclk_rise = sclk_s & ~sclk_d_reg;
  wire sclk_fall = ~sclk_s & sclk_d_reg;
  wire cs_rise   = cs_n_s & ~cs_d_reg;

  ////////////////////////////////////////////////////////////////////////
  // Status state

  reg [4:0]  bp_reg;
  reg [1:0]  srp_reg;
  reg        cmp_reg;
  reg        wel_reg;
  reg        sus_reg;
  reg        hpf_reg;
  reg        sr_busy_reg;
  reg [15:0] cnt_reg;

  // (R5) status word layout
  wire [15:0] status_word = {sus_reg, cmp_reg, SEC_LOCK, hpf_reg, QUAD_EN,
                             srp_reg, bp_reg, wel_reg, BUSY};

  // (R17) quad mode turns the protect pin into a data line
  wire wp_eff = QUAD_EN | wp_s;

  ////////////////////////////////////////////////////////////////////////
  // Frame shifter

  reg [2:0]  bit_cnt_reg;
  reg [2:0]  byte_cnt_reg;
  reg [7:0]  sh_reg;
  reg [7:0]  opcode_reg;
  reg [23:0] addr_reg;
  reg [7:0]  rd_sh_reg;
  reg        rd_on_reg;

  wire [7:0] byte_in = {sh_reg[6:0], si_s};
  wire [7:0] cur_op  = (byte_cnt_reg == 3'h0) ? byte_in : opcode_reg;
  wire       is_rd0  = (cur_op == `FSP_OP_RDSR0);
  wire       is_rd1  = (cur_op == `FSP_OP_RDSR1);

  // Shift in on SCLK rise, shift status out on SCLK fall
  always @(posedge SYS_CLK) begin
    if (!RST_N || cs_n_s) begin
      bit_cnt_reg  <= 3'h0;
      byte_cnt_reg <= 3'h0;
      rd_on_reg    <= 1'b0;
      SO_OE_N      <= 1'b1;
      if (!RST_N) begin
        sh_reg     <= 8'h00;
        opcode_reg <= 8'h00;
        addr_reg   <= 24'h000000;
        rd_sh_reg  <= 8'h00;
        SO         <= 1'b0;
      end
    end else if (sclk_rise) begin
      sh_reg      <= byte_in;
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      if (bit_cnt_reg == 3'h7) begin
        if (byte_cnt_reg != 3'h7) begin
          byte_cnt_reg <= byte_cnt_reg + 3'h1;
        end
        if (byte_cnt_reg == 3'h0) begin
          opcode_reg <= byte_in;
        end else if (byte_cnt_reg <= 3'h3) begin
          addr_reg <= {addr_reg[15:0], byte_in};
        end
        // Status read repeats its byte for as long as the frame runs
        if (is_rd0 || is_rd1) begin
          rd_sh_reg <= is_rd0 ? status_word[7:0] : status_word[15:8];
          rd_on_reg <= 1'b1;
        end
      end
    end else if (sclk_fall && rd_on_reg) begin
      SO        <= rd_sh_reg[7];
      rd_sh_reg <= {rd_sh_reg[6:0], 1'b0};
      SO_OE_N   <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command decode at frame end

  wire prot_hit;
  wire prot_none;

  fsp_prot_decode u_decode (
    .bp   (bp_reg),
    .cmp  (cmp_reg),
    .addr (addr_reg[18:0]),
    .hit  (prot_hit),
    .none (prot_none)
  );

  // Writes act only when the frame ends on a byte boundary
  wire frame_ok = cs_rise & (bit_cnt_reg == 3'h0);
  wire one_byte = (byte_cnt_reg == 3'h1);
  wire idle     = ~BUSY & ~sus_reg;

  wire is_write_enable_cmd = frame_ok & one_byte & ~BUSY & (opcode_reg == `FSP_OP_WRITE_ENABLE_CMD);
  wire is_write_disable_cmd = frame_ok & one_byte & ~BUSY & (opcode_reg == `FSP_OP_WRITE_DISABLE_CMD);
  wire is_status_write_cmd = frame_ok & idle &
                 (((opcode_reg == `FSP_OP_STATUS_WRITE_CMD) &&
                   ((byte_cnt_reg == 3'h2) || (byte_cnt_reg == 3'h3))) ||
                  ((opcode_reg == `FSP_OP_WRSR1) && (byte_cnt_reg == 3'h2)));
  wire is_pp   = (opcode_reg == `FSP_OP_PP) & (byte_cnt_reg >= 3'h5);
  wire is_se   = (opcode_reg == `FSP_OP_SE) & (byte_cnt_reg == 3'h4);
  wire is_be   = ((opcode_reg == `FSP_OP_BE32) || (opcode_reg == `FSP_OP_BE64)) &
                 (byte_cnt_reg == 3'h4);
  wire is_ce   = ((opcode_reg == `FSP_OP_CE0) || (opcode_reg == `FSP_OP_CE1)) & one_byte;

  // (R7) (R13) (R14) (R15) (R16) latch and lock gate status writes
  wire sr_ok = is_status_write_cmd & wel_reg & ~sr_locked(srp_reg, wp_eff);

  // (R7) (R10) (R12) latch and protected range gate array writes
  wire arr_ok = frame_ok & idle & wel_reg &
                (((is_pp | is_se | is_be) & ~prot_hit) | (is_ce & prot_none));

  wire is_susp   = frame_ok & one_byte & BUSY & ~sr_busy_reg &
                   (opcode_reg == `FSP_OP_SUSP);
  wire is_resume = frame_ok & one_byte & sus_reg & (opcode_reg == `FSP_OP_RESUME);
  wire op_done   = BUSY & (cnt_reg == 16'h0001);

  reg [15:0] wr_word;
  reg [1:0]  kind_next;

  // Merge written bytes over the current word
  always @* begin
    wr_word = status_word;
    if (opcode_reg == `FSP_OP_WRSR1) begin
      wr_word[15:8] = addr_reg[7:0];
    end else if (byte_cnt_reg == 3'h3) begin
      wr_word = {addr_reg[7:0], addr_reg[15:8]};
    end else begin
      wr_word[7:0] = addr_reg[7:0];
    end
  end

  // Array operation kind from the opcode
  always @* begin
    if (is_pp) begin
      kind_next = `FSP_KIND_PP;
    end else if (is_se) begin
      kind_next = `FSP_KIND_SE;
    end else if (is_be) begin
      kind_next = `FSP_KIND_BE;
    end else begin
      kind_next = `FSP_KIND_CE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status bit updates and busy timer

  // Non-volatile bits, busy timer and suspend
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      // (R23) (R9) (R21) reload stored bits at power-up
      bp_reg      <= NV_INIT[`FSP_BP_MSB:`FSP_BP_LSB];
      cmp_reg     <= NV_INIT[`FSP_BIT_CMP];
      QUAD_EN     <= NV_INIT[`FSP_BIT_QE];
      SEC_LOCK    <= NV_INIT[`FSP_LB_MSB:`FSP_LB_LSB];
      // (R15) power cycle ends the supply lock-down
      srp_reg     <= (NV_INIT[`FSP_SRP_MSB:`FSP_SRP_LSB] == `FSP_LOCK_PWR) ?
                     `FSP_LOCK_SW : NV_INIT[`FSP_SRP_MSB:`FSP_SRP_LSB];
      // (R23) (R22) volatile flags clear
      BUSY        <= 1'b0;
      sus_reg     <= 1'b0;
      hpf_reg     <= 1'b0;
      sr_busy_reg <= 1'b0;
      cnt_reg     <= 16'h0000;
      OP_START    <= 1'b0;
      OP_KIND     <= `FSP_KIND_PP;
      OP_ADDR     <= 19'h00000;
    end else begin
      // (R19) flag follows the mode level
      hpf_reg  <= hpm_s;
      OP_START <= arr_ok;
      if (sr_ok) begin
        // (R9) (R11) (R21) (R17) writable bits taken from the write
        bp_reg      <= wr_word[`FSP_BP_MSB:`FSP_BP_LSB];
        srp_reg     <= wr_word[`FSP_SRP_MSB:`FSP_SRP_LSB];
        QUAD_EN     <= wr_word[`FSP_BIT_QE];
        cmp_reg     <= wr_word[`FSP_BIT_CMP];
        // (R20) lock bits only ever set
        SEC_LOCK    <= SEC_LOCK | wr_word[`FSP_LB_MSB:`FSP_LB_LSB];
        // (R6) busy while the word is written
        BUSY        <= 1'b1;
        sr_busy_reg <= 1'b1;
        cnt_reg     <= SR_CYC;
      end else if (arr_ok) begin
        // (R6) busy while array changes
        BUSY        <= 1'b1;
        sr_busy_reg <= 1'b0;
        cnt_reg     <= op_cycles(kind_next);
        OP_KIND     <= kind_next;
        OP_ADDR     <= addr_reg[18:0];
      end else if (is_susp) begin
        // (R22) suspend pauses the timer
        BUSY    <= 1'b0;
        sus_reg <= 1'b1;
      end else if (is_resume) begin
        // (R22) resume continues the timer
        BUSY    <= 1'b1;
        sus_reg <= 1'b0;
      end else if (BUSY) begin
        if (op_done) begin
          BUSY <= 1'b0;
        end else begin
          cnt_reg <= cnt_reg - 16'h0001;
        end
      end
    end
  end

  // Write latch
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      wel_reg <= 1'b0;
    end else if (is_write_enable_cmd) begin
      // (R8) set by write enable
      wel_reg <= 1'b1;
    end else if (is_write_disable_cmd || op_done) begin
      // (R8) cleared by disable or completion
      wel_reg <= 1'b0;
    end
  end

endmodule

`default_nettype wire

/* test/fsp_host_model.sv */
// Host side of the serial link: shifts whole byte frames onto the pins.
// Assumes the bench system clock; link clock period is 8 system cycles.
`timescale 1ns/1ps
`default_nettype none

module fsp_host_model (
  // Clock
  input  wire logic clk,
  // Link pins
  output var  logic cs_n,
  output var  logic sclk,
  output var  logic si,
  input  wire logic so
);
  // Deselected, link clock parked low between frames
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si   = 1'b0;
  end

  ////////////////////////////////////////////////////////////
  // Frame of n bytes MSB first; rx keeps the last byte read back
  task automatic xfer(input logic [39:0] tx, input int n, output logic [7:0] rx);
    @(posedge clk) cs_n <= 1'b0;
    for (int i = 0; i < 8 * n; i++) begin
      si <= tx[39-i];
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      rx = {rx[6:0], so};
      repeat (4) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    // Released data line does not keep its last level
    si   <= ~si;
    repeat (8) @(posedge clk);
  endtask
endmodule

`default_nettype wire

/* test/fsp_status_protect_sva.sv */
// Port checks of the flash status and protection block.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none

module fsp_status_protect_sva #(
  parameter [15:0] CE_CYC = 16'h0400
) (
  // System
  input wire logic       SYS_CLK,
  input wire logic       RST_N,
  // Link
  input wire logic       CS_N,
  input wire logic       SCLK,
  input wire logic       SO_OE_N,
  // Array and mode outputs
  input wire logic       OP_START,
  input wire logic [1:0] OP_KIND,
  input wire logic       BUSY,
  input wire logic       QUAD_EN,
  input wire logic [2:0] SEC_LOCK
);
  logic [3:0]  cs_hi_cnt_reg;
  logic [16:0] busy_cnt_reg;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  // Cycles since chip select went high, saturating
  always @(posedge SYS_CLK) begin
    if (!RST_N || !CS_N) cs_hi_cnt_reg <= 4'h0;
    else if (cs_hi_cnt_reg != 4'hF) cs_hi_cnt_reg <= cs_hi_cnt_reg + 4'h1;
  end
  // Length of the current busy stretch
  always @(posedge SYS_CLK) begin
    if (!RST_N || !BUSY) busy_cnt_reg <= 17'h0;
    else busy_cnt_reg <= busy_cnt_reg + 17'h1;
  end

  ////////////////////////////////////////////////////////////
  // outputs quiet after reset
  AST_RESET_QUIET: assert property (disable iff (1'b0) !RST_N |=> SO_OE_N && !OP_START && !BUSY)
    else $error("outputs active after a reset cycle");
  // ops start only at frame end
  AST_START_AFTER_FRAME: assert property (OP_START |-> cs_hi_cnt_reg inside {[4'h1:4'h8]})
    else $error("array op started away from frame end");
  AST_START_WHEN_IDLE: assert property (OP_START |-> !$past(BUSY))
    else $error("array op started while busy");
  AST_BUSY_HOLDS: assert property ($rose(BUSY) |-> BUSY [*8])
    else $error("busy dropped too early");
  AST_BUSY_BOUNDED: assert property (busy_cnt_reg <= {1'b0, CE_CYC} + 17'h1)
    else $error("busy longer than the longest operation");
  AST_OE_IDLE: assert property (CS_N [*6] |-> SO_OE_N)
    else $error("data out enabled while deselected");
  AST_OE_FALL: assert property ($fell(SO_OE_N) |-> !CS_N && !SCLK)
    else $error("data out enabled outside a clock low phase");
  AST_LOCK_BITS_KEEP: assert property ((SEC_LOCK & $past(SEC_LOCK)) == $past(SEC_LOCK))
    else $error("security lock bit cleared");
  AST_NV_AT_FRAME_END: assert property (($changed(QUAD_EN) || $changed(SEC_LOCK)) |-> CS_N)
    else $error("stored bit changed inside a frame");

  // Main scenarios reached
  COV_CHIP_ERASE: cover property (OP_START && OP_KIND == 2'h3);
  COV_STATUS_READ: cover property ($fell(SO_OE_N));
  COV_BUSY_DONE: cover property ($fell(BUSY));
endmodule

bind fsp_status_protect fsp_status_protect_sva #(
  .CE_CYC (CE_CYC)
) i_fsp_status_protect_sva (
  .SYS_CLK  (SYS_CLK),
  .RST_N    (RST_N),
  .CS_N     (CS_N),
  .SCLK     (SCLK),
  .SO_OE_N  (SO_OE_N),
  .OP_START (OP_START),
  .OP_KIND  (OP_KIND),
  .BUSY     (BUSY),
  .QUAD_EN  (QUAD_EN),
  .SEC_LOCK (SEC_LOCK)
);

`default_nettype wire

/* test/fsp_status_protect_tb.sv */
// Self-checking bench of the flash status and protection block.
// Assumes the host model drives the link; erase busy times are shortened, status write busy is doubled.
`timescale 1ns/1ps
`default_nettype none

module fsp_status_protect_tb;
  // Clock, reset and pins
  logic        sys_clk   = 1'b0;
  logic        rst_n     = 1'b0;
  logic        wp_n      = 1'b1;
  logic        high_perf = 1'b0;
  logic        cs_n;
  logic        sclk;
  logic        si;
  logic        so;
  logic        so_oe_n;
  logic        op_start;
  logic [1:0]  op_kind;
  logic [18:0] op_addr;
  logic        busy;
  logic        quad_en;
  logic [2:0]  sec_lock;
  // Bookkeeping
  int          n_mismatch = 0;
  int          n_compared = 0;
  logic        seen       = 1'b0;
  logic [1:0]  seen_kind;
  logic [18:0] seen_addr;
  logic [7:0]  rd;

  always #50 sys_clk = ~sys_clk;

  fsp_status_protect #(.SR_CYC(16'h0040), .PP_CYC(16'h0040), .ER_CYC(16'h00C0), .CE_CYC(16'h0100))
  i_fsp_status_protect (.SYS_CLK(sys_clk), .RST_N(rst_n), .CS_N(cs_n), .SCLK(sclk), .SI(si), .SO(so),
    .SO_OE_N(so_oe_n), .WP_N(wp_n), .HIGH_PERF(high_perf), .OP_START(op_start), .OP_KIND(op_kind),
    .OP_ADDR(op_addr), .BUSY(busy), .QUAD_EN(quad_en), .SEC_LOCK(sec_lock));
  // Released data out shows the inverse of its last level, so a late enable is caught
  fsp_host_model i_fsp_host_model (.clk(sys_clk), .cs_n(cs_n), .sclk(sclk), .si(si), .so(so_oe_n ? ~so : so));

  // Remember the last accepted array operation
  always @(posedge sys_clk) begin
    if (op_start === 1'b1) begin
      seen      <= 1'b1;
      seen_kind <= op_kind;
      seen_addr <= op_addr;
    end
  end

  ////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t %s: got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  task automatic xfer(input logic [39:0] f, input int n);
    i_fsp_host_model.xfer(f, n, rd);
  endtask
  task automatic rd_chk(input logic [7:0] op, input logic [7:0] exp);
    xfer({op, 32'h0}, 2);
    check(rd, exp, "status byte");
  endtask
  task automatic wait_idle;
    for (int k = 0; k < 4000 && busy !== 1'b0; k++) @(posedge sys_clk);
    check(busy, 1'b0, "busy at end");
  endtask
  task automatic wrx(input logic [39:0] f, input int n);
    xfer({8'h06, 32'h0}, 1);
    xfer(f, n);
    wait_idle;
  endtask
  task automatic status_write_cmd(input logic [7:0] lo, input logic [7:0] hi);
    wrx({8'h01, lo, hi, 16'h0}, 3);
  endtask
  task automatic pwr_cycle;
    @(posedge sys_clk) rst_n <= 1'b0;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
  endtask
  // Latch set, array op, acceptance and fields judged, latch dropped
  task automatic arr_op(input logic [7:0] op, input logic [18:0] a, input logic acc, input logic [1:0] kind);
    xfer({8'h06, 32'h0}, 1);
    seen = 1'b0;
    xfer({op, 5'h0, a, 8'h5A}, (op == 8'h02) ? 5 : (op == 8'h60 || op == 8'hC7) ? 1 : 4);
    check(seen, acc, "op accepted");
    if (acc) check({seen_kind, seen_addr}, {kind, (kind == 2'h3) ? seen_addr : a}, "op fields");
    wait_idle;
    xfer({8'h04, 32'h0}, 1);
  endtask
  task automatic t_one(input logic c, input logic [4:0] bp, input logic [18:0] a, input logic acc);
    status_write_cmd({1'b0, bp, 2'b00}, {1'b0, c, 6'h00});
    arr_op(8'h20, a, acc, 2'h1);
  endtask

  ////////////////////////////////////////////////////////////
  task automatic t_reset;
    check({busy, quad_en, sec_lock}, 5'h00, "reset pins");
    rd_chk(8'h05, 8'h00);
    rd_chk(8'h35, 8'h00);
  endtask
  task automatic t_latch;
    xfer({8'h01, 8'h1C, 24'h0}, 2);
    rd_chk(8'h05, 8'h00);
    xfer({8'h06, 32'h0}, 1);
    rd_chk(8'h05, 8'h02);
    xfer({8'h04, 32'h0}, 1);
    rd_chk(8'h05, 8'h00);
    xfer({8'h06, 32'h0}, 1);
    xfer({8'h01, 8'h0C, 8'h00, 16'h0}, 3);
    check(busy, 1'b1, "busy status write");
    wait_idle;
    rd_chk(8'h05, 8'h0C);
  endtask
  task automatic t_prot;
    t_one(1'b1, 5'h00, 19'h00000, 1'b0);
    t_one(1'b1, 5'h04, 19'h7FFFF, 1'b1);
    t_one(1'b1, 5'h1F, 19'h00000, 1'b1);
    t_one(1'b1, 5'h01, 19'h6FFFF, 1'b0);
    t_one(1'b1, 5'h01, 19'h70000, 1'b1);
    t_one(1'b1, 5'h0A, 19'h1FFFF, 1'b1);
    t_one(1'b1, 5'h0A, 19'h20000, 1'b0);
    t_one(1'b1, 5'h11, 19'h7EFFF, 1'b0);
    t_one(1'b1, 5'h11, 19'h7F000, 1'b1);
    t_one(1'b1, 5'h1C, 19'h07FFF, 1'b1);
    t_one(1'b1, 5'h1C, 19'h08000, 1'b0);
    t_one(1'b0, 5'h01, 19'h6FFFF, 1'b1);
    t_one(1'b0, 5'h01, 19'h70000, 1'b0);
    t_one(1'b0, 5'h11, 19'h7F000, 1'b0);
    t_one(1'b0, 5'h00, 19'h00000, 1'b1);
  endtask
  task automatic t_ops;
    arr_op(8'h02, 19'h00100, 1'b1, 2'h0);
    arr_op(8'hD8, 19'h12345, 1'b1, 2'h2);
    arr_op(8'h52, 19'h7FFFF, 1'b1, 2'h2);
    arr_op(8'h60, 19'h00000, 1'b1, 2'h3);
    arr_op(8'hC7, 19'h00000, 1'b1, 2'h3);
    status_write_cmd(8'h04, 8'h00);
    arr_op(8'hC7, 19'h00000, 1'b0, 2'h3);
    arr_op(8'h02, 19'h70000, 1'b0, 2'h0);
    status_write_cmd(8'h00, 8'h00);
  endtask
  task automatic t_lock;
    @(posedge sys_clk) wp_n <= 1'b0;
    status_write_cmd(8'h04, 8'h00);
    rd_chk(8'h05, 8'h04);
    status_write_cmd(8'h80, 8'h00);
    status_write_cmd(8'h84, 8'h00);
    rd_chk(8'h05, 8'h82);
    xfer({8'h04, 32'h0}, 1);
    @(posedge sys_clk) wp_n <= 1'b1;
    status_write_cmd(8'h84, 8'h00);
    rd_chk(8'h05, 8'h84);
    // Quad enable set while the protect pin is driven, never tied
    status_write_cmd(8'h84, 8'h02);
    check(quad_en, 1'b1, "quad enable");
    @(posedge sys_clk) wp_n <= 1'b0;
    status_write_cmd(8'h80, 8'h02);
    rd_chk(8'h05, 8'h80);
    status_write_cmd(8'h00, 8'h01);
    @(posedge sys_clk) wp_n <= 1'b1;
    status_write_cmd(8'h04, 8'h00);
    rd_chk(8'h05, 8'h02);
    pwr_cycle;
    rd_chk(8'h35, 8'h00);
    status_write_cmd(8'h80, 8'h01);
    status_write_cmd(8'h04, 8'h00);
    rd_chk(8'h05, 8'h82);
    pwr_cycle;
  endtask
  task automatic t_sec;
    wrx({8'h31, 8'h08, 24'h0}, 2);
    check(sec_lock, 3'h1, "lock bits");
    wrx({8'h31, 8'h10, 24'h0}, 2);
    check(sec_lock, 3'h3, "lock bits kept");
  endtask
  task automatic t_susp;
    @(posedge sys_clk) high_perf <= 1'b1;
    rd_chk(8'h35, 8'h1C);
    xfer({8'h06, 32'h0}, 1);
    xfer({8'hD8, 5'h0, 19'h40000, 8'h00}, 4);
    check(busy, 1'b1, "busy erase");
    xfer({8'h75, 32'h0}, 1);
    check(busy, 1'b0, "busy suspended");
    rd_chk(8'h35, 8'h9C);
    xfer({8'h7A, 32'h0}, 1);
    check(busy, 1'b1, "busy resumed");
    wait_idle;
    rd_chk(8'h05, 8'h00);
  endtask

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_reset;
    t_latch;
    t_prot;
    t_ops;
    t_lock;
    t_sec;
    t_susp;
    print_verdict;
  end
  // Watchdog well beyond the expected run length
  initial begin
    repeat (80000) @(posedge sys_clk);
    n_mismatch++;
    print_verdict;
  end
endmodule

`default_nettype wire
